// *** hdl/catcd_consts.vh ***
`ifndef CATCD_CONSTS_VH
`define CATCD_CONSTS_VH

// Register byte offsets.
`define CATCD_OFF_HDR   12'h000
`define CATCD_OFF_LEN   12'h004
`define CATCD_OFF_CMD   12'h008
`define CATCD_OFF_CTRL  12'h00C
`define CATCD_OFF_RESP  12'h010
`define CATCD_OFF_STAT  12'h014
`define CATCD_OFF_PEND  12'h018

// Header register fields, low bit of each byte.
`define CATCD_HDR_INS   0
`define CATCD_HDR_P1    8
`define CATCD_HDR_P2    16
`define CATCD_HDR_LC    24

// Length register fields.
`define CATCD_LEN_LE    0
`define CATCD_LEN_LEP   8
`define CATCD_LEN_LCP   9

// Command register bits.
`define CATCD_CMD_GO    0
`define CATCD_CMD_RST   1

// Control register bits.
`define CATCD_CTRL_APP  0
`define CATCD_CTRL_LEG  1

// Status register fields.
`define CATCD_STAT_SW   0
`define CATCD_STAT_CLS  16
`define CATCD_STAT_ACC  19
`define CATCD_STAT_PV   20
`define CATCD_STAT_1ST  21
`define CATCD_STAT_KSP  22
`define CATCD_STAT_KIM  23
`define CATCD_STAT_KNM  24

// Reset values.
`define CATCD_RST_BYTE  8'h00
`define CATCD_RST_CTRL  2'h0
`define CATCD_RST_SW    16'h0000
`define CATCD_RST_CLS   3'h0
`define CATCD_RST_KNUM  5'h00

`endif

// *** hdl/catcd_decoder.v ***
`timescale 1ns/100ps
`include "catcd_consts.vh"
// Notes on behaviour
// - Authenticate needs P1 zero; algorithm comes from the selected application.
// - P2 b8 picks global or specific key, b7-b6 zero, number 01-1F.
// - P2 all zero means implicit key of the selected application.
// - Authenticate needs Lc and Le; response is limited to Le bytes.
// - Envelope needs P1 P2 zero and Lc; optional Le caps the response.
// - Fetch needs P1 P2 zero, no Lc, Le present; answer up to Le.
// - Only authenticate, search record, select and increase leave pending data; an authenticate refused for P2 b7-b6 nonzero keeps earlier pending data.
// - Get response out of sequence answers technical problem status.
// - Legacy mode accepts get response as first command after activation.
module catcd_decoder #(
    parameter [7:0]  INS_AUTH = 8'h88,
    parameter [7:0]  INS_TP   = 8'h10,
    parameter [7:0]  INS_ENV  = 8'hC2,
    parameter [7:0]  INS_FET  = 8'h12,
    parameter [7:0]  INS_TR   = 8'h14,
    parameter [7:0]  INS_GR   = 8'hC0,
    parameter [7:0]  INS_SRCH = 8'hA2,
    parameter [7:0]  INS_SEL  = 8'hA4,
    parameter [7:0]  INS_INC  = 8'h32,
    parameter [15:0] SW_OK    = 16'h9000,
    parameter [15:0] SW_P1P2  = 16'h6B00,
    parameter [15:0] SW_LEN   = 16'h6700,
    parameter [15:0] SW_INS   = 16'h6D00,
    parameter [15:0] SW_COND  = 16'h6985,
    parameter [15:0] SW_TECH  = 16'h6F00
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         dec_done,
    output reg  [2:0]  dec_class,
    output reg         dec_accept,
    output reg  [7:0]  resp_max
);

localparam [2:0] CL_OTHER = 3'h0;
localparam [2:0] CL_AUTH  = 3'h1;
localparam [2:0] CL_TP    = 3'h2;
localparam [2:0] CL_ENV   = 3'h3;
localparam [2:0] CL_FET   = 3'h4;
localparam [2:0] CL_TR    = 3'h5;
localparam [2:0] CL_GR    = 3'h6;
localparam [2:0] CL_PROD  = 3'h7;

reg  [7:0]  ins;
reg  [7:0]  p1;
reg  [7:0]  p2;
reg  [7:0]  lc;
reg  [7:0]  le;
reg         le_pres;
reg         lc_pres;
reg         app_sel;
reg         legacy_ok;
reg  [7:0]  pend_len;
reg  [15:0] sw;
reg  [2:0]  cls;
reg         accept;
reg         pend_valid;
reg  [7:0]  pend_src;
reg         first_cmd;
reg         key_spec;
reg         key_impl;
reg  [4:0]  key_num;

reg  [15:0] next_sw;
reg  [2:0]  next_cls;
reg         next_pend_valid;
reg  [7:0]  next_pend_src;
reg         next_key_spec;
reg         next_key_impl;
reg  [4:0]  next_key_num;
reg  [7:0]  next_resp;
reg  [31:0] next_rdata;
reg         next_err;

wire        wr_en = psel & penable & pwrite & pready;
wire        setup = psel & ~penable;
wire        go    = wr_en && (paddr == `CATCD_OFF_CMD) && pwdata[`CATCD_CMD_GO];
wire        rst_s = wr_en && (paddr == `CATCD_OFF_CMD) && pwdata[`CATCD_CMD_RST];

// Checks the zero parameter bytes first, then the length fields.
function [15:0] hdr_sw;
    input [7:0] a;
    input [7:0] b;
    input       len_bad;
    begin
        if (a != 8'h00 || b != 8'h00) begin
            hdr_sw = SW_P1P2;
        end else if (len_bad) begin
            hdr_sw = SW_LEN;
        end else begin
            hdr_sw = SW_OK;
        end
    end
endfunction

// Decodes the held command header into a status and pending state.
always @* begin
    next_sw         = SW_INS;
    next_cls        = CL_OTHER;
    next_pend_valid = 1'b0;
    next_pend_src   = pend_src;
    next_key_spec   = key_spec;
    next_key_impl   = key_impl;
    next_key_num    = key_num;
    next_resp       = 8'h00;
    case (ins)
        INS_AUTH: begin
            next_cls = CL_AUTH;
            if (!app_sel) begin
                next_sw = SW_COND;
            end else if (p1 != 8'h00) begin
                next_sw = SW_P1P2;
            end else if (p2[6:5] != 2'b00) begin
                next_sw         = SW_P1P2;
                next_pend_valid = pend_valid;
            end else if (p2 != 8'h00 && p2[4:0] == 5'h00) begin
                next_sw = SW_P1P2;
            end else if (!lc_pres || !le_pres) begin
                next_sw = SW_LEN;
            end else begin
                next_sw         = SW_OK;
                next_key_spec   = p2[7];
                next_key_num    = p2[4:0];
                next_key_impl   = (p2 == 8'h00);
                next_resp       = le;
                next_pend_valid = 1'b1;
                next_pend_src   = ins;
            end
        end
        INS_TP: begin
            next_cls = CL_TP;
            next_sw  = hdr_sw(p1, p2, !lc_pres || le_pres);
        end
        INS_ENV: begin
            next_cls  = CL_ENV;
            next_sw   = hdr_sw(p1, p2, !lc_pres);
            next_resp = le_pres ? le : 8'h00;
        end
        INS_FET: begin
            next_cls  = CL_FET;
            next_sw   = hdr_sw(p1, p2, lc_pres || !le_pres);
            next_resp = le;
        end
        INS_TR: begin
            next_cls = CL_TR;
            next_sw  = hdr_sw(p1, p2, !lc_pres || le_pres);
        end
        INS_GR: begin
            next_cls = CL_GR;
            if (hdr_sw(p1, p2, lc_pres) != SW_OK) begin
                next_sw = hdr_sw(p1, p2, lc_pres);
            end else if (pend_valid) begin
                if (le_pres && le != 8'h00 && le != pend_len) begin
                    next_sw = SW_LEN;
                end else begin
                    next_sw   = SW_OK;
                    next_resp = (le_pres && le != 8'h00) ? le : pend_len;
                end
            end else if (first_cmd && legacy_ok) begin
                next_sw       = SW_OK;
                next_pend_src = INS_SEL;
                next_resp     = (le_pres && le != 8'h00) ? le : pend_len;
            end else begin
                next_sw = SW_TECH;
            end
        end
        INS_SRCH, INS_SEL, INS_INC: begin
            next_cls        = CL_PROD;
            next_sw         = SW_OK;
            next_pend_valid = 1'b1;
            next_pend_src   = ins;
        end
        default: begin
            next_sw = SW_INS;
        end
    endcase
end

// Read data and error answer, prepared in the setup cycle.
always @* begin
    next_err = 1'b0;
    case (paddr)
        `CATCD_OFF_HDR: begin
            next_rdata = {lc, p2, p1, ins};
        end
        `CATCD_OFF_LEN: begin
            next_rdata = {22'h000000, lc_pres, le_pres, le};
        end
        `CATCD_OFF_CMD: begin
            next_rdata = 32'h00000000;
        end
        `CATCD_OFF_CTRL: begin
            next_rdata = {30'h00000000, legacy_ok, app_sel};
        end
        `CATCD_OFF_RESP: begin
            next_rdata = {24'h000000, pend_len};
        end
        `CATCD_OFF_STAT: begin
            next_rdata = {3'h0, key_num, key_impl, key_spec, first_cmd,
                          pend_valid, accept, cls, sw};
        end
        `CATCD_OFF_PEND: begin
            next_rdata = {8'h00, resp_max, pend_src, pend_len};
        end
        default: begin
            next_rdata = 32'h00000000;
            next_err   = 1'b1;
        end
    endcase
end

// Bus answer: no wait states, data and error registered at setup.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready  <= 1'b0;
        prdata  <= 32'h00000000;
        pslverr <= 1'b0;
    end else begin
        pready <= 1'b1;
        if (setup) begin
            prdata  <= pwrite ? 32'h00000000 : next_rdata;
            pslverr <= next_err;
        end
    end
end

// Software writable registers.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ins       <= `CATCD_RST_BYTE;
        p1        <= `CATCD_RST_BYTE;
        p2        <= `CATCD_RST_BYTE;
        lc        <= `CATCD_RST_BYTE;
        le        <= `CATCD_RST_BYTE;
        le_pres   <= 1'b0;
        lc_pres   <= 1'b0;
        app_sel   <= 1'b0;
        legacy_ok <= 1'b0;
        pend_len  <= `CATCD_RST_BYTE;
    end else if (wr_en) begin
        if (paddr == `CATCD_OFF_HDR) begin
            ins <= pwdata[`CATCD_HDR_INS +: 8];
            p1  <= pwdata[`CATCD_HDR_P1 +: 8];
            p2  <= pwdata[`CATCD_HDR_P2 +: 8];
            lc  <= pwdata[`CATCD_HDR_LC +: 8];
        end
        if (paddr == `CATCD_OFF_LEN) begin
            le      <= pwdata[`CATCD_LEN_LE +: 8];
            le_pres <= pwdata[`CATCD_LEN_LEP];
            lc_pres <= pwdata[`CATCD_LEN_LCP];
        end
        if (paddr == `CATCD_OFF_CTRL) begin
            app_sel   <= pwdata[`CATCD_CTRL_APP];
            legacy_ok <= pwdata[`CATCD_CTRL_LEG];
        end
        if (paddr == `CATCD_OFF_RESP) begin
            pend_len <= pwdata[7:0];
        end
    end
end

// Decode result and sequence state, updated on the go write.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sw         <= `CATCD_RST_SW;
        cls        <= `CATCD_RST_CLS;
        accept     <= 1'b0;
        pend_valid <= 1'b0;
        pend_src   <= `CATCD_RST_BYTE;
        first_cmd  <= 1'b1;
        key_spec   <= 1'b0;
        key_impl   <= 1'b0;
        key_num    <= `CATCD_RST_KNUM;
        dec_done   <= 1'b0;
        dec_class  <= `CATCD_RST_CLS;
        dec_accept <= 1'b0;
        resp_max   <= `CATCD_RST_BYTE;
    end else begin
        dec_done <= go;
        if (go) begin
            sw         <= next_sw;
            cls        <= next_cls;
            accept     <= (next_sw == SW_OK);
            pend_valid <= next_pend_valid;
            pend_src   <= next_pend_src;
            first_cmd  <= 1'b0;
            key_spec   <= next_key_spec;
            key_impl   <= next_key_impl;
            key_num    <= next_key_num;
            dec_class  <= next_cls;
            dec_accept <= (next_sw == SW_OK);
            resp_max   <= next_resp;
        end else if (rst_s) begin
            pend_valid <= 1'b0;
            first_cmd  <= 1'b1;
        end
    end
end

endmodule // catcd_decoder

// *** tb/card_auth_toolkit_cmd_decoder_tb.sv ***
`timescale 1ns/100ps
`include "catcd_consts.vh"
module card_auth_toolkit_cmd_decoder_tb;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    wire        psel, penable, pwrite, pready, pslverr, dec_done, dec_accept;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [2:0]  dec_class;
    wire [7:0]  resp_max;
    logic [31:0] st, r;
    int fails = 0;
    int check_count = 0;
    logic [7:0] prod [3] = '{8'hA2, 8'hA4, 8'h32};
    int cmd_count = 0;
    int done_count = 0;
    always #50 pclk = ~pclk;
    // Counts decode pulses so that a missing or stuck pulse shows up at the end.
    always @(posedge pclk) begin
        if (dec_done === 1'b1) done_count++;
    end
    catcd_decoder catcd_decoder_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dec_done(dec_done),
        .dec_class(dec_class), .dec_accept(dec_accept), .resp_max(resp_max));
    catcd_terminal catcd_terminal_inst (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (e !== s) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask
    task automatic cmd(input logic [7:0] ins, p1, p2, le, input logic [1:0] fl,
                       input logic [15:0] sw);
        cmd_count++;
        catcd_terminal_inst.send(ins, p1, p2, le, fl, st);
        chk("status", {16'h0, sw}, {16'h0, st[15:0]});
        chk("accept", {31'h0, sw == 16'h9000}, {31'h0, dec_accept});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        catcd_terminal_inst.xfer(1'b1, a, d, r);
    endtask
    task automatic conclude;
        if (catcd_terminal_inst.tmo) fails++;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        catcd_terminal_inst.xfer(1'b0, `CATCD_OFF_STAT, 32'h0, r);
        chk("stat_reset", 32'h0020_0000, r);
        catcd_terminal_inst.xfer(1'b0, 12'h01C, 32'h0, r);
        chk("unmapped", 32'h1, {31'h0, catcd_terminal_inst.err});
        wr(`CATCD_OFF_CTRL, 32'h2);
        cmd(8'hC0, 8'h00, 8'h00, 8'h00, 2'h1, 16'h9000);
        chk("class", 32'h6, {29'h0, dec_class});
        catcd_terminal_inst.xfer(1'b0, `CATCD_OFF_PEND, 32'h0, r);
        chk("pend", 32'h0000_A400, r);
        cmd(8'hC0, 8'h00, 8'h00, 8'h00, 2'h1, 16'h6F00);
        wr(`CATCD_OFF_CMD, 32'h2);
        cmd(8'hC0, 8'h00, 8'h00, 8'h00, 2'h1, 16'h9000);
        $display("test legacy first command done");
        cmd(8'h88, 8'h00, 8'h81, 8'h20, 2'h3, 16'h6985);
        wr(`CATCD_OFF_CTRL, 32'h3);
        catcd_terminal_inst.xfer(1'b0, `CATCD_OFF_CTRL, 32'h0, r);
        chk("ctrl", 32'h3, r);
        cmd(8'h88, 8'h01, 8'h81, 8'h20, 2'h3, 16'h6B00);
        cmd(8'h88, 8'h00, 8'h40, 8'h20, 2'h3, 16'h6B00);
        cmd(8'h88, 8'h00, 8'h80, 8'h20, 2'h3, 16'h6B00);
        cmd(8'h88, 8'h00, 8'h81, 8'h20, 2'h2, 16'h6700);
        cmd(8'h88, 8'h00, 8'h9F, 8'h20, 2'h3, 16'h9000);
        chk("key", 32'h7D, {25'h0, st[28:22]});
        chk("resp_max", 32'h20, {24'h0, resp_max});
        cmd(8'h88, 8'h00, 8'h00, 8'h08, 2'h3, 16'h9000);
        chk("key_implicit", 32'h1, {31'h0, st[23]});
        wr(`CATCD_OFF_RESP, 32'h10);
        cmd(8'h88, 8'h00, 8'h20, 8'h08, 2'h3, 16'h6B00);
        chk("pending", 32'h1, {31'h0, st[20]});
        cmd(8'hC0, 8'h00, 8'h00, 8'h10, 2'h1, 16'h9000);
        chk("resp_max", 32'h10, {24'h0, resp_max});
        cmd(8'h88, 8'h00, 8'h01, 8'h08, 2'h3, 16'h9000);
        cmd(8'hC0, 8'h00, 8'h00, 8'h05, 2'h1, 16'h6700);
        cmd(8'h88, 8'h00, 8'h01, 8'h08, 2'h3, 16'h9000);
        cmd(8'hC2, 8'h00, 8'h00, 8'h00, 2'h2, 16'h9000);
        chk("resp_max", 32'h0, {24'h0, resp_max});
        cmd(8'hC0, 8'h00, 8'h00, 8'h00, 2'h1, 16'h6F00);
        $display("test authenticate and get response done");
        for (int i = 0; i < 3; i++) begin
            cmd(prod[i], 8'h00, 8'h00, 8'h00, 2'h0, 16'h9000);
            chk("class", 32'h7, {29'h0, dec_class});
            cmd(8'hC0, 8'h00, 8'h00, 8'h00, 2'h1, 16'h9000);
        end
        cmd(8'h12, 8'h00, 8'h00, 8'h30, 2'h1, 16'h9000);
        chk("resp_max", 32'h30, {24'h0, resp_max});
        cmd(8'hC0, 8'h00, 8'h00, 8'h00, 2'h1, 16'h6F00);
        cmd(8'h12, 8'h00, 8'h00, 8'h30, 2'h3, 16'h6700);
        cmd(8'h10, 8'h00, 8'h00, 8'h00, 2'h2, 16'h9000);
        cmd(8'h10, 8'h00, 8'h00, 8'h08, 2'h3, 16'h6700);
        cmd(8'hC2, 8'h00, 8'h00, 8'h08, 2'h3, 16'h9000);
        chk("resp_max", 32'h8, {24'h0, resp_max});
        cmd(8'hC2, 8'h00, 8'h01, 8'h08, 2'h3, 16'h6B00);
        cmd(8'h14, 8'h00, 8'h00, 8'h00, 2'h2, 16'h9000);
        cmd(8'h14, 8'h01, 8'h00, 8'h00, 2'h2, 16'h6B00);
        cmd(8'hC0, 8'h01, 8'h00, 8'h00, 2'h1, 16'h6B00);
        cmd(8'hC0, 8'h00, 8'h00, 8'h00, 2'h3, 16'h6700);
        cmd(8'h55, 8'h00, 8'h00, 8'h00, 2'h0, 16'h6D00);
        $display("test toolkit commands done");
        chk("done_count", cmd_count, done_count);
        conclude();
    end
endmodule // card_auth_toolkit_cmd_decoder_tb

// *** tb/catcd_asserts.sv ***
`timescale 1ns/100ps
`include "catcd_consts.vh"
module catcd_asserts (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        dec_done,
    input wire [2:0]  dec_class,
    input wire        dec_accept,
    input wire [7:0]  resp_max
);
    reg  [31:0] hdr;
    reg  [9:0]  len;
    wire        acc = psel && penable && pready && pwrite;
    wire        go  = acc && paddr == `CATCD_OFF_CMD && pwdata[0];
    wire [7:0]  ins = hdr[7:0];
    wire        pz  = hdr[23:8] == 16'h0000;
    // Shadow copies of the command header and length words.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdr <= 32'h0;
            len <= 10'h0;
        end else if (acc && paddr == `CATCD_OFF_HDR) begin
            hdr <= pwdata;
        end else if (acc && paddr == `CATCD_OFF_LEN) begin
            len <= pwdata[9:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_go;
        go;
    endsequence
    sequence s_pulse;
        dec_done ##1 !dec_done;
    endsequence
    AST_DONE: assert property (s_go |=> s_pulse)
        else $error("done pulse missing");
    AST_READY: assert property (psel && penable |-> pready)
        else $error("wait state seen");
    AST_ERR: assert property (psel && penable && paddr > 12'h018 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_AUTH_RSV: assert property (s_go ##0 (ins == 8'h88 && hdr[22:21] != 2'h0)
        |=> dec_class == 3'h1 && !dec_accept) else $error("reserved key bits accepted");
    AST_AUTH_P1: assert property (s_go ##0 (ins == 8'h88 && hdr[15:8] != 8'h00)
        |=> !dec_accept) else $error("nonzero algorithm byte accepted");
    AST_AUTH_LE: assert property (s_go ##0 ins == 8'h88
        |=> !dec_accept || resp_max == len[7:0]) else $error("auth length cap wrong");
    AST_FETCH: assert property (s_go ##0 (ins == 8'h12 && pz && len[9:8] == 2'h1)
        |=> dec_accept && dec_class == 3'h4 && resp_max == len[7:0])
        else $error("fetch decode wrong");
    AST_ENV: assert property (s_go ##0 (ins == 8'hC2 && pz && len[9:8] == 2'h2)
        |=> dec_accept && resp_max == 8'h00) else $error("envelope decode wrong");
    AST_SEL: assert property (s_go ##0 (ins == 8'hA4 || ins == 8'hA2 || ins == 8'h32)
        |=> dec_accept && dec_class == 3'h7) else $error("pending producer decode wrong");
endmodule // catcd_asserts
bind catcd_decoder catcd_asserts catcd_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dec_done(dec_done), .dec_class(dec_class), .dec_accept(dec_accept),
    .resp_max(resp_max));

// *** tb/catcd_terminal.sv ***
`timescale 1ns/100ps
`include "catcd_consts.vh"
module catcd_terminal (
    input  wire        pclk,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr,
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [11:0] paddr,
    output reg  [31:0] pwdata
);
    reg tmo = 1'b0;
    reg err = 1'b0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        tmo = tmo | (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
        paddr <= ~a;
    endtask
    // One command: header, length flags, go, then status read back.
    task automatic send(input logic [7:0] ins, p1, p2, le, input logic [1:0] fl,
                        output logic [31:0] st);
        logic [31:0] r;
        xfer(1'b1, `CATCD_OFF_HDR, {8'h10, p2, p1, ins}, r);
        xfer(1'b1, `CATCD_OFF_LEN, {22'h0, fl, le}, r);
        xfer(1'b1, `CATCD_OFF_CMD, 32'h1, r);
        xfer(1'b0, `CATCD_OFF_STAT, 32'h0, st);
    endtask
endmodule // catcd_terminal
